// [cfg_loader_monitor.sv]
// Purpose: port assertions of the configuration loader
// Assumes: zero-wait apb slave
// Notes:   bound to the top module
`timescale 1ns/1ps
module cfg_loader_monitor (
  input wire logic        pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        pready, pslverr, flash_rd, flash_rvalid,
  input wire logic [7:0]  flash_addr,
  input wire logic        cpu_run, flash_read_en, debug_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read data");
  chk_rd_pulse: assert property (flash_rd |=> !flash_rd) else $error("flash read too long");
  chk_addr_range: assert property (flash_rd |-> flash_addr[7:4] == 4'h7)
    else $error("flash address range");
  chk_dbg_gated: assert property (debug_en |-> flash_read_en)
    else $error("debug without unlock");
  chk_unlock_cause: assert property ($rose(flash_read_en) |->
    $past(psel && penable && pwrite && paddr == 12'h000 && pwdata[0], 2))
    else $error("unlock without compare");
  chk_dbg_cause: assert property ($rose(debug_en) |-> $rose(flash_read_en))
    else $error("debug rose alone");
  chk_run_hold: assert property (cpu_run |=> cpu_run) else $error("run dropped");
  cover property ($rose(debug_en));
  cover property ($rose(cpu_run));
  cover property (pslverr);
endmodule // cfg_loader_monitor

bind flash_cfg_loader cfg_loader_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_rd, .flash_rvalid, .flash_addr,
  .cpu_run, .flash_read_en, .debug_en);

// [flash_cfg_loader.v]
// Purpose: loads the authorization code and option byte after reset,
//          holds the stabilization wait and gates debug access
// Assumes: flash read port answers each read with one rvalid pulse
// Notes:   APB slave with zero wait states, unmapped addresses give pslverr
`timescale 1ns/1ps
`include "flash_cfg_regs.vh"
module flash_cfg_loader #(
  parameter EXP_BASE = `STAB_EXP_BASE
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // flash read port
  output reg         flash_rd,
  output reg  [7:0]  flash_addr,
  input  wire [7:0]  flash_rdata,
  input  wire        flash_rvalid,
  // main oscillator pin
  input  wire        osc_in,
  // device control
  output reg         cpu_run,
  output reg         flash_read_en,
  output reg         debug_en
);
  localparam [1:0] S_FETCH = 2'h0;
  localparam [1:0] S_WAIT  = 2'h1;
  localparam [1:0] S_RUN   = 2'h2;

  // register decode codes
  localparam [2:0] RC_NONE   = 3'h0;
  localparam [2:0] RC_CTRL   = 3'h1;
  localparam [2:0] RC_STATUS = 3'h2;
  localparam [2:0] RC_KEY0   = 3'h3;
  localparam [2:0] RC_KEY1   = 3'h4;
  localparam [2:0] RC_KEY2   = 3'h5;
  localparam [2:0] RC_OPT    = 3'h6;

  reg  [1:0]  state_q;
  reg  [4:0]  idx_q;
  reg         pend_q;
  reg  [7:0]  cfg_mem [0:15];
  reg  [31:0] key0_q;
  reg  [31:0] key1_q;
  reg  [15:0] key2_q;
  reg         unlocked_q;
  reg         mismatch_q;
  reg  [2:0]  osc_sync_q;
  reg         osc_prev_q;
  reg         osc_tick;
  wire        stab_done;
  wire        setup_ph;
  wire        access_ph;
  wire        wr_en;
  wire        addr_ok;
  wire        code_match;
  wire [2:0]  stab_sel;
  wire        dbg_flag;
  wire [2:0]  acc_code;
  wire        loaded;
  wire [31:0] status_word;
  wire        wr_ctrl;
  wire        wr_key0;
  wire        wr_key1;
  wire        wr_key2;
  wire        stab_start;
  integer     i;
  integer     j;

  // presented code byte n, low byte of key0 first
  function [7:0] key_byte;
    input [3:0]  n;
    input [31:0] k0;
    input [31:0] k1;
    input [15:0] k2;
    begin
      case (n)
        4'h0: key_byte = k0[7:0];
        4'h1: key_byte = k0[15:8];
        4'h2: key_byte = k0[23:16];
        4'h3: key_byte = k0[31:24];
        4'h4: key_byte = k1[7:0];
        4'h5: key_byte = k1[15:8];
        4'h6: key_byte = k1[23:16];
        4'h7: key_byte = k1[31:24];
        4'h8: key_byte = k2[7:0];
        4'h9: key_byte = k2[15:8];
        default: key_byte = 8'h00;
      endcase
    end
  endfunction

  // ten-byte comparison, any differing byte fails
  function code_eq;
    input [31:0] k0;
    input [31:0] k1;
    input [15:0] k2;
    input [79:0] stored;
    integer b;
    begin
      code_eq = 1'b1;
      for (b = 0; b < 10; b = b + 1) begin
        if (key_byte(b[3:0], k0, k1, k2) != stored[b*8 +: 8]) begin
          code_eq = 1'b0;
        end
      end
    end
  endfunction

  reg [79:0] stored_code;
  always @* begin
    stored_code = 80'h0;
    for (j = 0; j < 10; j = j + 1) begin
      stored_code[j*8 +: 8] = cfg_mem[j];
    end
  end

  assign stab_sel   = cfg_mem[`CFG_OPT_INDEX][2:0];
  assign dbg_flag   = cfg_mem[`CFG_AUTH_LAST][`CFG_DBG_EN_BIT];
  assign code_match = code_eq(key0_q, key1_q, key2_q, stored_code);

  // register decode, shared by write, read and error paths
  function [2:0] reg_code;
    input [11:0] a;
    begin
      case (a)
        `REG_CTRL:     reg_code = RC_CTRL;
        `REG_STATUS:   reg_code = RC_STATUS;
        `REG_KEY0:     reg_code = RC_KEY0;
        `REG_KEY1:     reg_code = RC_KEY1;
        `REG_KEY2:     reg_code = RC_KEY2;
        `REG_OPT_ADDR: reg_code = RC_OPT;
        default:       reg_code = RC_NONE;
      endcase
    end
  endfunction

  // apb decode
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign acc_code  = reg_code(paddr);
  assign addr_ok   = (acc_code != RC_NONE);
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !addr_ok;
  assign wr_en     = access_ph && pwrite && addr_ok;
  assign wr_ctrl   = wr_en && (acc_code == RC_CTRL);
  assign wr_key0   = wr_en && (acc_code == RC_KEY0);
  assign wr_key1   = wr_en && (acc_code == RC_KEY1);
  assign wr_key2   = wr_en && (acc_code == RC_KEY2);

  // status word, one field per line
  assign loaded      = (state_q != S_FETCH);
  assign status_word = {21'h0,
                        stab_sel,
                        3'h0,
                        mismatch_q,
                        debug_en,
                        unlocked_q,
                        cpu_run,
                        loaded};

  // wait timer starts once the fetch is over
  assign stab_start = (state_q == S_WAIT);

  // oscillator pin: three stages, edge counts when stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_q <= 3'h0;
      osc_prev_q <= 1'b0;
      osc_tick   <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], osc_in};
      osc_tick   <= 1'b0;
      if (osc_sync_q[1] == osc_sync_q[2]) begin
        osc_prev_q <= osc_sync_q[2];
        osc_tick   <= osc_sync_q[2] && !osc_prev_q;
      end
    end
  end

  // configuration fetch after reset release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= S_FETCH;
      idx_q      <= 5'h00;
      pend_q     <= 1'b0;
      flash_rd   <= 1'b0;
      flash_addr <= 8'h00;
      cpu_run    <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        cfg_mem[i] <= 8'h00;
      end
    end else begin
      flash_rd <= 1'b0;
      case (state_q)
        S_FETCH: begin
          if (idx_q == `CFG_FLASH_BYTES) begin
            state_q <= S_WAIT;
          end else if (!pend_q) begin
            flash_rd   <= 1'b1;
            flash_addr <= `CFG_FLASH_BASE + {3'h0, idx_q};
            pend_q     <= 1'b1;
          end else if (flash_rvalid) begin
            if (idx_q[3:0] == `CFG_OPT_INDEX) begin
              cfg_mem[idx_q[3:0]] <= flash_rdata & `CFG_OPT_SEL_MASK;
            end else begin
              cfg_mem[idx_q[3:0]] <= flash_rdata;
            end
            pend_q <= 1'b0;
            idx_q  <= idx_q + 5'h01;
          end
        end
        S_WAIT: begin
          if (stab_done) begin
            state_q <= S_RUN;
            cpu_run <= 1'b1;
          end
        end
        S_RUN: begin
          cpu_run <= 1'b1;
        end
        default: begin
          state_q <= S_FETCH;
        end
      endcase
    end
  end

  stab_wait_timer #(
    .EXP_BASE (EXP_BASE),
    .SEL_W    (`STAB_SEL_W)
  ) u_stab (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (stab_start),
    .sel      (stab_sel),
    .osc_tick (osc_tick),
    .done_q   (stab_done)
  );

  // presented code and authorization
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key0_q        <= 32'h0;
      key1_q        <= 32'h0;
      key2_q        <= 16'h0;
      unlocked_q    <= 1'b0;
      mismatch_q    <= 1'b0;
      flash_read_en <= 1'b0;
      debug_en      <= 1'b0;
    end else begin
      if (wr_key0) begin
        key0_q <= pwdata;
      end
      if (wr_key1) begin
        key1_q <= pwdata;
      end
      if (wr_key2) begin
        key2_q <= pwdata[15:0];
      end
      // compare only once the stored code is loaded
      if (wr_ctrl && pwdata[`CTRL_COMPARE] && loaded) begin
        unlocked_q <= code_match;
        mismatch_q <= !code_match;
      end
      flash_read_en <= unlocked_q;
      debug_en      <= unlocked_q && dbg_flag;
    end
  end

  // read data captured in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup_ph && !pwrite) begin
      case (acc_code)
        RC_STATUS: begin
          prdata <= status_word;
        end
        RC_KEY0: begin
          prdata <= key0_q;
        end
        RC_KEY1: begin
          prdata <= key1_q;
        end
        RC_KEY2: begin
          prdata <= {16'h0, key2_q};
        end
        RC_OPT: begin
          prdata <= {24'h0, cfg_mem[`CFG_OPT_INDEX]};
        end
        default: begin
          prdata <= 32'h0;
        end
      endcase
    end
  end
endmodule // flash_cfg_loader

// [flash_cfg_regs.vh]
// Purpose: constants for the reset-time configuration loader
// Assumes: APB byte addresses, 32-bit data, one register per aligned word
// Notes:   flash addresses are byte addresses of the internal flash
`ifndef FLASH_CFG_REGS_VH
`define FLASH_CFG_REGS_VH

// flash layout
`define CFG_FLASH_BASE    8'h70
`define CFG_FLASH_BYTES   5'h10
`define CFG_AUTH_BYTES    4'hA
`define CFG_AUTH_LAST     4'h9
`define CFG_OPT_INDEX     4'hA
`define CFG_DBG_EN_BIT    3'h7
`define CFG_OPT_SEL_MASK  8'h07

// register map: byte addresses
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_KEY0          12'h008
`define REG_KEY1          12'h00C
`define REG_KEY2          12'h010
`define REG_OPT_INDEX     12'h07A
`define REG_OPT_ADDR      12'h1E8

// control and status fields
`define CTRL_COMPARE      0
`define ST_LOADED         0
`define ST_RUNNING        1
`define ST_UNLOCKED       2
`define ST_DEBUG_EN       3
`define ST_MISMATCH       4
`define ST_SEL_LO         8

// stabilization: count is 2^(base + select) oscillator periods
`define STAB_EXP_BASE     10
`define STAB_SEL_W        3

`endif

// [flash_model.sv]
// Purpose: behavioural model of the internal flash read port
// Assumes: one read outstanding, answer 1 to 4 cycles after the read is sampled
// Notes:   data lines toggle while no answer is given
`timescale 1ns/1ps
module flash_model (
  // clock
  input  wire logic       pclk,
  // request
  input  wire logic       rd,
  input  wire logic [7:0] addr,
  // answer
  output logic      [7:0] rdata,
  output logic            rvalid
);
  logic [7:0] mem [0:15];
  logic [7:0] a_q;
  logic [1:0] wait_q;
  logic       pend_q;
  initial begin
    rdata = 8'h00;
    rvalid = 1'b0;
    pend_q = 1'b0;
  end
  // answer delay varies with the address to mix prompt and slow replies
  always @(posedge pclk) begin
    rvalid <= 1'b0;
    rdata <= ~rdata;
    if (rd) begin
      pend_q <= 1'b1;
      a_q <= addr;
      wait_q <= addr[1:0];
    end else if (pend_q && wait_q == 2'h0) begin
      rvalid <= 1'b1;
      rdata <= mem[a_q[3:0]];
      pend_q <= 1'b0;
    end else if (pend_q) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule // flash_model

// [stab_wait_timer.v]
// Purpose: oscillation stabilization wait after reset release
// Assumes: osc_tick is a one-cycle pulse per oscillator period
// Notes:   done stays high once the wait has elapsed
`timescale 1ns/1ps
`include "flash_cfg_regs.vh"
module stab_wait_timer #(
  parameter EXP_BASE = `STAB_EXP_BASE,
  parameter SEL_W    = `STAB_SEL_W
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // control
  input  wire             start,
  input  wire [SEL_W-1:0] sel,
  input  wire             osc_tick,
  // status
  output reg              done_q
);
  localparam CNT_W = EXP_BASE + (1 << SEL_W);

  reg [CNT_W-1:0] cnt_q;
  reg             busy_q;
  wire            hit;

  // power-of-two count reached when the selected bit sets
  assign hit = cnt_q[EXP_BASE + sel];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= {CNT_W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start && !busy_q && !done_q) begin
      busy_q <= 1'b1;
      cnt_q  <= {CNT_W{1'b0}};
    end else if (busy_q) begin
      if (hit) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end else if (osc_tick) begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // stab_wait_timer

// [testbench.sv]
// Purpose: self-checking bench of the configuration loader
// Assumes: wait exponent base set to 0, oscillator period 6 clocks
// Notes:   each round reprograms flash and resets
`timescale 1ns/1ps
`include "flash_cfg_regs.vh"
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc_in = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, flash_rd, flash_rvalid, cpu_run, flash_read_en, debug_en, err;
  logic [7:0]  flash_addr, flash_rdata, opt;
  logic [79:0] code, key;
  logic [1:0]  eo;
  integer      seed = 32'h72CB, num_errors = 0, tests_run = 0, cyc = 0, k, n;
  flash_cfg_loader #(.EXP_BASE(0)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .flash_rd, .flash_addr, .flash_rdata,
    .flash_rvalid, .osc_in, .cpu_run, .flash_read_en, .debug_en);
  flash_model fm (.pclk, .rd(flash_rd), .addr(flash_addr), .rdata(flash_rdata),
    .rvalid(flash_rvalid));
  initial forever #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 0) osc_in <= ~osc_in;
    if (cyc == 40000) begin
      num_errors++;
      complete_run;
    end
  end
  function logic [1:0] exp_out(input integer m); // unlocked, debug
    exp_out = {m != 2, m == 0 || m == 3};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task boot;
    integer i;
    for (i = 0; i < 10; i++) fm.mem[i] = code[8*i+:8];
    fm.mem[10] = opt;
    for (i = 11; i < 16; i++) fm.mem[i] = 8'h00;
    presetn <= 0;
    repeat (3) @(posedge pclk);
    chk({cpu_run, flash_read_en, debug_en, pready}, 32'h1);
    presetn <= 1;
    do apb(0, `REG_STATUS, 0); while (rdat[0] !== 1'b1);
    chk(rdat[10:8], opt[2:0]);
    if (opt[2:0] > 1) chk(cpu_run, 0);
    n = 0;
    while (cpu_run !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 6*(2**opt[2:0]) - 14 && n <= 6*(2**opt[2:0]) + 12, 1);
  endtask
  task complete_run;
    $display("errors %0d compares %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    for (k = 0; k < 8; k++) begin
      code[31:0] = $random(seed);
      code[63:32] = $random(seed);
      code[79:64] = $random(seed);
      opt = $random(seed);
      code[79] = (k % 4 != 1);
      if (k % 4 == 3) code = {80{1'b1}};
      key = code;
      n = $unsigned($random(seed)) % 10;
      if (k % 4 == 2) key[8*n+:8] = ~key[8*n+:8];
      boot;
      apb(0, `REG_OPT_ADDR, 0);
      chk(rdat, {29'h0, opt[2:0]});
      apb(1, `REG_KEY0, key[31:0]);
      apb(1, `REG_KEY1, key[63:32]);
      apb(1, `REG_KEY2, {16'h0, key[79:64]});
      apb(0, `REG_KEY2, 0);
      chk(rdat, {16'h0, key[79:64]});
      apb(1, `REG_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      chk({flash_read_en, debug_en}, exp_out(k % 4));
      apb(0, `REG_STATUS, 0);
      eo = exp_out(k % 4);
      chk(rdat[4:2], {k % 4 == 2, eo[0], eo[1]});
      apb(0, 12'h020, 0);
      chk(err, 1'b1);
      chk(rdat, 32'h0);
    end
    complete_run;
  end
endmodule // testbench
